//--- sector_guard_pkg.sv
// Notes on behaviour
// - Program/erase blocked when nonvolatile guard is 0
// - Guards program singly to 0, erase together
// - Guard program/erase refused while latch is 0
// - Progress shown in readable status register
// - Volatile guard write clears or sets bit freely
// - Sector unprotected only when both guards 1
// - Latch 0 freezes nonvolatile guards, 1 allows changes
// - Latch clear command clears latch to 0
// - Persistent mode: latch 1 at reset, no reset-free set
// - Software reset leaves latch unchanged
// - Password mode: latch 0 at reset, unlock sets; code's hardware reset returns mode word to 11, so latch comes up 1
// - Full 64-bit exact match sets latch
// - Password program only turns ones to zeros
// - Password erased all ones, own address space
// - After password mode, program ignored, read undefined
// - Mismatch sets program error, keeps busy, latch 0
// - Unlock rate-limited to one per 100 us; code holds busy only after a mismatch, a match finishes in 2 cycles
// - Mode bits never erasable, choice permanent; code's hardware reset returns mode word to 11
// - Error status read only from readable sectors
// - Block range and sector guards ORed
// - Mode bits 11/10 persistent, 01 password, 00 error
package sector_guard_pkg;
    localparam int unsigned SECTORS = 32;
    localparam int unsigned SECT_W = 5;
    localparam logic [11:0] A_CMD = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_PASS_LO = 12'h008;
    localparam logic [11:0] A_PASS_HI = 12'h00c;
    localparam logic [11:0] A_NV = 12'h010;
    localparam logic [11:0] A_VOL = 12'h014;
    localparam logic [11:0] A_BLOCK = 12'h018;
    localparam logic [11:0] A_MODE = 12'h01c;
    localparam logic [11:0] A_PROT = 12'h020;
    localparam logic [11:0] A_ECCSEL = 12'h024;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [63:0] PASS_RESET = 64'hffffffffffffffff;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned PROG_NS = 2000;
    localparam int unsigned ERASE_NS = 8000;
    localparam int unsigned UNLOCK_US = 100;
    localparam int unsigned PROG_CYC = PROG_NS * CLK_MHZ / 1000;
    localparam int unsigned ERASE_CYC = ERASE_NS * CLK_MHZ / 1000;
    localparam int unsigned UNLOCK_CYC = UNLOCK_US * CLK_MHZ;
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_GUARD_PROG = 4'h1,
        CMD_GUARD_ERASE = 4'h2,
        CMD_VOL_WRITE = 4'h3,
        CMD_LATCH_CLEAR = 4'h4,
        CMD_UNLOCK = 4'h5,
        CMD_PASS_PROG = 4'h6,
        CMD_MODE_PROG = 4'h7,
        CMD_SOFT_RESET = 4'h8,
        CMD_ARRAY_WRITE = 4'h9
    } cmd_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_HOLD = 2'b10
    } op_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;
endpackage

//--- flash_sector_protection.sv
`timescale 1ns/10ps
module flash_sector_protection import sector_guard_pkg::*; #(
    parameter int unsigned UNLOCK_CYCLES = UNLOCK_CYC,
    parameter int unsigned PROG_CYCLES = PROG_CYC,
    parameter int unsigned ERASE_CYCLES = ERASE_CYC
) (
    input wire logic sys_clk_i, // System clock 125 MHz
    input wire logic nrst_i, // Hardware reset, active low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [11:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    output logic [SECTORS-1:0] sector_locked_o, // Per-sector program/erase block
    output logic operation_in_progress_o // Busy flag
);
    typedef struct packed {
        apb_rsp_type rsp;
        op_type op;
        cmd_type cmd;
        logic [31:0] cnt;
        logic [SECTORS-1:0] nonvolatile_sector_guard;
        logic [SECTORS-1:0] volatile_sector_guard;
        logic guard_freeze_latch;
        logic [1:0] protection_mode_word;
        logic [63:0] password;
        logic [63:0] attempt;
        logic [SECT_W-1:0] target;
        logic prog_err;
        logic [SECTORS-1:0] block_range;
        logic [SECTORS-1:0] locked;
        logic [SECT_W-1:0] ecc_sect;
        logic read_prot;
        logic busy;
    } state_type;
    state_type r, next_r;
    logic [SECTORS-1:0] eff_lock;
    logic pw_mode;
    logic wr_acc, rd_acc;
    logic boot_done;
    assign pw_mode = (r.protection_mode_word == 2'b01);
    assign wr_acc = psel_i && penable_i && pwrite_i && !r.rsp.pready;
    assign rd_acc = psel_i && penable_i && !pwrite_i && !r.rsp.pready;
    genvar g;
    generate
        for (g = 0; g < SECTORS; g++) begin : g_lock
            // Unprotected only if both guards are 1 and outside the block range
            assign eff_lock[g] = !(r.nonvolatile_sector_guard[g]
                && r.volatile_sector_guard[g]) || r.block_range[g];
        end
    endgenerate
    always_comb begin
        next_r = r;
        next_r.rsp.pready = 1'b0;
        next_r.rsp.pslverr = 1'b0;
        next_r.rsp.prdata = 32'h0;
        next_r.locked = eff_lock;
        // Reset value of the latch follows the stored mode, applied on the first clock
        if (!boot_done) begin
            next_r.guard_freeze_latch = !pw_mode;
        end
        // Embedded operations
        unique case (r.op)
            ST_IDLE: begin
            end
            ST_BUSY: begin
                if (r.cnt != 32'h0) begin
                    next_r.cnt = r.cnt - 32'h1;
                end else begin
                    next_r.op = ST_IDLE;
                    unique case (r.cmd)
                        CMD_GUARD_PROG: next_r.nonvolatile_sector_guard[r.target] = 1'b0;
                        CMD_GUARD_ERASE: next_r.nonvolatile_sector_guard = '1;
                        CMD_UNLOCK: begin
                            if (r.attempt == r.password) begin
                                next_r.guard_freeze_latch = 1'b1;
                            end else begin
                                next_r.prog_err = 1'b1;
                                next_r.op = ST_HOLD;
                                next_r.cnt = 32'(UNLOCK_CYCLES - 1);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_HOLD: begin
                // Failed unlock keeps busy for the rate-limit window
                if (r.cnt != 32'h0) begin
                    next_r.cnt = r.cnt - 32'h1;
                end else begin
                    next_r.op = ST_IDLE;
                end
            end
            default: next_r.op = ST_IDLE;
        endcase
        if (wr_acc) begin
            next_r.rsp.pready = 1'b1;
            unique case (paddr_i)
                A_CMD: begin
                    // Commands other than soft reset are dropped while busy
                    if (cmd_type'(pwdata_i[3:0]) == CMD_SOFT_RESET) begin
                        next_r.volatile_sector_guard = '1;
                    end else if (r.op == ST_IDLE) begin
                        next_r.target = pwdata_i[8+SECT_W-1:8];
                        next_r.cmd = cmd_type'(pwdata_i[3:0]);
                        unique case (cmd_type'(pwdata_i[3:0]))
                            CMD_GUARD_PROG, CMD_GUARD_ERASE: begin
                                if (r.guard_freeze_latch) begin
                                    next_r.op = ST_BUSY;
                                    next_r.prog_err = 1'b0;
                                    next_r.cnt = (pwdata_i[3:0] == 4'h1) ?
                                        32'(PROG_CYCLES - 1) : 32'(ERASE_CYCLES - 1);
                                end else begin
                                    next_r.prog_err = 1'b1;
                                end
                            end
                            CMD_VOL_WRITE: begin
                                next_r.volatile_sector_guard[pwdata_i[8+SECT_W-1:8]] =
                                    pwdata_i[16];
                            end
                            CMD_LATCH_CLEAR: next_r.guard_freeze_latch = 1'b0;
                            CMD_UNLOCK: begin
                                if (pw_mode) begin
                                    next_r.op = ST_BUSY;
                                    next_r.prog_err = 1'b0;
                                    next_r.cnt = 32'h1;
                                end
                            end
                            CMD_PASS_PROG: begin
                                if (r.protection_mode_word == MODE_RESET) begin
                                    next_r.password = r.password & r.attempt;
                                end
                            end
                            CMD_MODE_PROG: begin
                                // Only 1->0, never erased; reaching 00 fails
                                if (r.protection_mode_word != MODE_RESET) begin
                                    next_r.prog_err = 1'b1;
                                end else if ((r.protection_mode_word & pwdata_i[17:16])
                                    == 2'b00) begin
                                    next_r.prog_err = 1'b1;
                                end else begin
                                    next_r.protection_mode_word = pwdata_i[17:16];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                A_PASS_LO: next_r.attempt[31:0] = pwdata_i;
                A_PASS_HI: next_r.attempt[63:32] = pwdata_i;
                A_BLOCK: next_r.block_range = pwdata_i[SECTORS-1:0];
                A_PROT: next_r.read_prot = pwdata_i[0];
                A_ECCSEL: next_r.ecc_sect = pwdata_i[SECT_W-1:0];
                default: next_r.rsp.pslverr = 1'b1;
            endcase
        end else if (rd_acc) begin
            next_r.rsp.pready = 1'b1;
            unique case (paddr_i)
                A_STATUS: next_r.rsp.prdata = {26'h0, r.protection_mode_word,
                    r.guard_freeze_latch, r.prog_err, 1'b0, r.op != ST_IDLE};
                A_PASS_LO: next_r.rsp.prdata = (r.protection_mode_word == MODE_RESET ||
                    r.protection_mode_word == 2'b10) ? r.password[31:0] : 32'h0;
                A_PASS_HI: next_r.rsp.prdata = (r.protection_mode_word == MODE_RESET ||
                    r.protection_mode_word == 2'b10) ? r.password[63:32] : 32'h0;
                A_NV: next_r.rsp.prdata = r.nonvolatile_sector_guard;
                A_VOL: next_r.rsp.prdata = r.volatile_sector_guard;
                A_BLOCK: next_r.rsp.prdata = r.block_range;
                A_MODE: next_r.rsp.prdata = {30'h0, r.protection_mode_word};
                A_PROT: next_r.rsp.prdata = {31'h0, r.read_prot};
                // Readback picks boot sector 0 under read protection
                A_ECCSEL: next_r.rsp.prdata = {27'h0,
                    r.read_prot ? SECT_W'(0) : r.ecc_sect};
                default: next_r.rsp.pslverr = 1'b1;
            endcase
        end
        next_r.busy = (next_r.op != ST_IDLE);
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r.rsp <= '0;
            r.op <= ST_IDLE;
            r.cmd <= CMD_NONE;
            r.cnt <= 32'h0;
            r.nonvolatile_sector_guard <= '1;
            r.volatile_sector_guard <= '1;
            r.guard_freeze_latch <= 1'b0;
            r.protection_mode_word <= MODE_RESET;
            r.password <= PASS_RESET;
            r.attempt <= '0;
            r.target <= '0;
            r.prog_err <= 1'b0;
            r.block_range <= '0;
            r.locked <= '0;
            r.ecc_sect <= '0;
            r.read_prot <= 1'b0;
            r.busy <= 1'b0;
        end else begin
            r <= next_r;
        end
    end
    // Latch state after reset depends on stored mode; set on first clocked cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_done <= 1'b0;
        end else begin
            boot_done <= 1'b1;
        end
    end
    assign prdata_o = r.rsp.prdata;
    assign pready_o = r.rsp.pready;
    assign pslverr_o = r.rsp.pslverr;
    assign sector_locked_o = r.locked;
    assign operation_in_progress_o = r.busy;
    chk_latch_frozen: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !r.guard_freeze_latch && r.op == ST_IDLE |=> $stable(r.nonvolatile_sector_guard))
        else $error("guards changed while latch clear");
    chk_vol_lock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !r.volatile_sector_guard[0] |=> sector_locked_o[0])
        else $error("sector 0 unlocked with volatile guard 0");
    chk_block_or: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        r.block_range[1] |=> sector_locked_o[1])
        else $error("block range ignored");
    chk_pass_ones: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ($past(r.password) & r.password) == r.password)
        else $error("password bit rose");
    chk_mode_never: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        r.protection_mode_word != 2'b00)
        else $error("illegal mode word");
    chk_mode_keep: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        r.protection_mode_word != MODE_RESET |=> $stable(r.protection_mode_word))
        else $error("mode changed after selection");
    chk_fail_busy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(r.op == ST_HOLD) |-> r.prog_err && !r.guard_freeze_latch
            && operation_in_progress_o)
        else $error("failed unlock effects wrong");
    chk_pers_noset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !pw_mode && boot_done && !r.guard_freeze_latch |=> !r.guard_freeze_latch)
        else $error("latch set in persistent mode");
endmodule

//--- apb_host.sv
`timescale 1ns/10ps
module apb_host (
    input wire logic sys_clk_i, // Bench clock
    input wire logic pready_i, // Slave ready
    input wire logic [31:0] prdata_i, // Slave read data
    input wire logic pslverr_i, // Slave error
    output logic psel_o, // Select
    output logic penable_o, // Enable
    output logic pwrite_o, // Direction
    output logic [11:0] paddr_o, // Byte address
    output logic [31:0] pwdata_o // Write data
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h00000000;
    end
    // Released address and write data get inverted so stale data never looks valid
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic tmo);
        tmo = 1'b1;
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= wr ? d : ~d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (pready_i === 1'b1) begin
                rd = prdata_i;
                err = pslverr_i;
                tmo = 1'b0;
                break;
            end
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~pwdata_o;
    endtask
endmodule

//--- flash_sector_protection_tb.sv
`timescale 1ns/10ps
module flash_sector_protection_tb import sector_guard_pkg::*; ;
    localparam int unsigned UNL = 20;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy, err, tmo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, vol_exp;
    logic [SECTORS-1:0] locked;
    int num_errors = 0;
    int samples_checked = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    apb_host i_host (.sys_clk_i(sys_clk_i), .pready_i(pready), .prdata_i(prdata),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));
    flash_sector_protection #(.UNLOCK_CYCLES(UNL), .PROG_CYCLES(5), .ERASE_CYCLES(10)) i_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sector_locked_o(locked),
        .operation_in_progress_o(busy));
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_count(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[FAIL] %0t %s: count %0d", $time, what, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(wr, a, d, rd, err, tmo);
        if (tmo !== 1'b0) begin
            num_errors++;
            $display("[FAIL] %0t bus answer missing", $time);
            give_verdict();
        end
    endtask
    // Command word: value bits, sector, opcode
    task automatic cmd(input logic [1:0] val, input int s, input cmd_type c, output int n);
        bus(1'b1, A_CMD, {14'h0, val, 3'h0, s[4:0], 4'h0, c});
        n = 0;
        @(posedge sys_clk_i);
        while (busy !== 1'b0 && n < 400) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 400) begin
            num_errors++;
            $display("[FAIL] %0t busy never dropped", $time);
            give_verdict();
        end
    endtask
    function automatic logic [31:0] stat(logic e, logic l, logic [1:0] m);
        return {26'h0, m, l, e, 2'b00};
    endfunction
    task automatic status(input logic [31:0] mask, input logic [31:0] exp, input string what);
        bus(1'b0, A_STATUS, 32'h0);
        chk_word(rd & mask, exp & mask, what);
    endtask
    task automatic attempt(input logic [63:0] p);
        bus(1'b1, A_PASS_HI, p[63:32]);
        bus(1'b1, A_PASS_LO, p[31:0]);
    endtask
    initial begin
        int n, s;
        logic [63:0] p1, p2;
        void'($urandom(36));
        vol_exp = '1;
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        status(32'h3d, stat(1'b0, 1'b1, 2'h3), "reset status");
        chk_word(locked, 32'h0, "reset locks");
        for (int i = 0; i < 12; i++) begin
            s = (i == 0) ? SECTORS - 1 : $urandom_range(SECTORS - 1);
            vol_exp[s] = (i < 2) ? 1'(i) : 1'($urandom_range(1));
            cmd({1'b0, vol_exp[s]}, s, CMD_VOL_WRITE, n);
            chk_word(locked, ~vol_exp, "volatile guard");
        end
        bus(1'b1, A_CMD, {14'h0, 2'b00, 3'h0, 5'd7, 4'h0, CMD_GUARD_PROG});
        status(32'h1, 32'h1, "busy while programming");
        repeat (12) @(posedge sys_clk_i);
        bus(1'b0, A_NV, 32'h0);
        chk_word(rd, 32'hffffff7f, "single guard programmed");
        chk_word(locked, ~vol_exp | 32'h80, "guard blocks sector");
        cmd(2'b00, 0, CMD_GUARD_ERASE, n);
        bus(1'b0, A_NV, 32'h0);
        chk_word(rd, 32'hffffffff, "group erase");
        bus(1'b1, A_BLOCK, 32'h2);
        @(posedge sys_clk_i);
        chk_word(locked, ~vol_exp | 32'h2, "block range ORed");
        bus(1'b1, A_BLOCK, 32'h0);
        bus(1'b1, A_ECCSEL, 32'h5);
        bus(1'b1, A_PROT, 32'h1);
        bus(1'b0, A_ECCSEL, 32'h0);
        chk_word(rd, 32'h0, "read protect forces boot sector");
        bus(1'b1, A_PROT, 32'h0);
        bus(1'b0, A_ECCSEL, 32'h0);
        chk_word(rd, 32'h5, "ecc sector select");
        cmd(2'b00, 0, CMD_MODE_PROG, n);
        status(32'h3d, stat(1'b1, 1'b1, 2'h3), "both mode bits refused");
        cmd(2'b00, 0, CMD_LATCH_CLEAR, n);
        status(32'h08, 32'h0, "latch cleared");
        cmd(2'b00, 3, CMD_GUARD_PROG, n);
        bus(1'b0, A_NV, 32'h0);
        chk_word(rd, 32'hffffffff, "frozen guards");
        cmd(2'b00, 0, CMD_SOFT_RESET, n);
        status(32'h08, 32'h0, "soft reset keeps latch");
        bus(1'b0, 12'h040, 32'h0);
        chk_word({31'h0, err}, 32'h1, "unmapped read");
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        status(32'h3d, stat(1'b0, 1'b1, 2'h3), "hardware reset sets latch");
        p1 = {$urandom, $urandom};
        p2 = {$urandom, $urandom};
        attempt(p1);
        cmd(2'b00, 0, CMD_PASS_PROG, n);
        attempt(p2);
        cmd(2'b00, 0, CMD_PASS_PROG, n);
        bus(1'b0, A_PASS_HI, 32'h0);
        chk_word(rd, p1[63:32] & p2[63:32], "password readable");
        cmd(2'b01, 0, CMD_MODE_PROG, n);
        status(32'h30, 32'h10, "password mode chosen");
        bus(1'b0, A_PASS_LO, 32'h0);
        chk_word(rd, 32'h0, "password hidden");
        cmd(2'b00, 0, CMD_LATCH_CLEAR, n);
        attempt(~(p1 & p2));
        cmd(2'b00, 0, CMD_UNLOCK, n);
        chk_count(n, UNL * 4 / 5, UNL * 6 / 5 + 8, "unlock hold-off");
        status(32'h0c, stat(1'b1, 1'b0, 2'h0), "wrong password");
        cmd(2'b10, 0, CMD_MODE_PROG, n);
        status(32'h30, 32'h10, "mode permanent");
        attempt(64'h0);
        cmd(2'b00, 0, CMD_PASS_PROG, n);
        attempt(p1 & p2);
        cmd(2'b00, 0, CMD_UNLOCK, n);
        chk_count(n, 0, 6, "fast good unlock");
        status(32'h08, 32'h08, "exact password unlocks");
        give_verdict();
    end
endmodule
